/* File: rtl/nrd_host.sv */
// host-side read sequencer for a parallel nand flash: page, cache, two-plane, random output
// Behaviour
// - cache reading starts with 00h then 30h; busy low during the load
// - random cache read is 00h, five address cycles, then 31h
// - two-plane read is 00h plus address, 00h plus address, then 30h
// - both two-plane addresses match except the plane-select bit
// - after two-plane read, issue 06h-E0h to pick each plane before reading
// - never issue enhanced status 78h while a two-plane read runs
// - column change is 05h, two column bytes, E0h, within the loaded page
// - plane select is 06h, two column, three row bytes, E0h, only when ready
// - wait write-to-read time after E0h before the first read strobe
`timescale 1ns/1ps
`default_nettype none
module nrd_host
    import nrd_pkg::*;
#(
    parameter int COL_W = 16,
    parameter int ROW_W = 24,
    parameter int LEN_W = 12,
    parameter int PLANE_BIT = 6,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire nrd_op_t cmd_op,
    input wire logic [COL_W-1:0] cmd_col,
    input wire logic [ROW_W-1:0] cmd_row,
    input wire logic [LEN_W-1:0] cmd_len,
    output logic cmd_ready,
    output logic cmd_done,
    output logic cmd_error,
    output logic out_valid,
    output logic [7:0] out_data,
    input wire logic out_ready,
    output logic chip_en_n,
    output logic command_latch_en,
    output logic address_latch_en,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic [7:0] io_out,
    output logic io_oe,
    input wire logic [7:0] io_in,
    input wire logic ready_busy_n
);
    // first command byte; 78h is never issued
    function automatic logic [7:0] first_cmd(input nrd_op_t op);
        case (op)
            OP_CACHE_SEQ: return CMD_CACHE_NEXT;
            OP_CACHE_LAST: return CMD_CACHE_LAST;
            OP_COL_OUT: return CMD_COL_OUT;
            OP_PLANE_OUT: return CMD_PLANE_OUT;
            default: return CMD_READ_SETUP;
        endcase
    endfunction : first_cmd

    // closing command byte; single-cycle commands have none
    function automatic logic [7:0] last_cmd(input nrd_op_t op);
        case (op)
            OP_CACHE_RAND: return CMD_CACHE_NEXT;
            OP_COL_OUT: return CMD_OUT_GO;
            OP_PLANE_OUT: return CMD_OUT_GO;
            default: return CMD_READ_GO;
        endcase
    endfunction : last_cmd

    function automatic logic [2:0] addr_cycles(input nrd_op_t op);
        case (op)
            OP_CACHE_SEQ: return ADDR_NONE;
            OP_CACHE_LAST: return ADDR_NONE;
            // column change sends two column bytes
            OP_COL_OUT: return ADDR_COL;
            default: return ADDR_FULL;
        endcase
    endfunction : addr_cycles

    nrd_state_t st_q;
    nrd_state_t st_d;
    nrd_op_t op_q;
    logic [COL_W-1:0] col_q;
    logic [ROW_W-1:0] row_q;
    logic [LEN_W-1:0] rem_q;
    logic [LEN_W-1:0] rem_d;
    logic [2:0] aidx_q;
    logic [2:0] aidx_d;
    logic [7:0] tmr_q;
    logic [7:0] tmr_d;
    logic ph_q;
    logic ph_d;
    logic pass_q;
    logic pass_d;
    logic plane_pend_q;
    logic finish;

    nrd_byte_if #(.WIDTH(8)) push_if ();
    nrd_byte_if #(.WIDTH(8)) pop_if ();

    nrd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset(reset),
        .push(push_if),
        .pop(pop_if)
    );

    wire logic accept = cmd_valid && cmd_ready;
    // column change refused after a two-plane read until another kind of command, such as a plane select, is started
    wire logic refuse = (cmd_op == OP_COL_OUT) && plane_pend_q;
    wire logic start = accept && !refuse;
    wire logic is_two = (op_q == OP_TWO_PLANE);
    wire logic has_last = (op_q != OP_CACHE_SEQ) && (op_q != OP_CACHE_LAST);
    wire logic [2:0] n_addr = addr_cycles(op_q);
    wire logic waits_busy = (op_q != OP_COL_OUT) && (op_q != OP_PLANE_OUT);
    wire logic reads = !is_two && (rem_q != '0);
    wire logic write_st = (st_q == ST_CMD1) || (st_q == ST_ADDR) || (st_q == ST_CMD2);
    wire logic [7:0] step_lim = write_st ? (ph_q ? WE_HIGH_CYC : WE_LOW_CYC)
                                         : (ph_q ? RE_HIGH_CYC : RE_LOW_CYC);
    wire logic step_end = (tmr_q == step_lim - 8'h01);
    // next-cycle view of the request, so a write byte is set up with its strobe
    wire nrd_op_t op_n = start ? cmd_op : op_q;
    wire logic [COL_W-1:0] col_n = start ? cmd_col : col_q;
    wire logic [ROW_W-1:0] row_n = start ? cmd_row : row_q;
    // plane-select bit cleared on the first pass, set on the second
    wire logic [ROW_W-1:0] plane_mask = ROW_W'(1) << PLANE_BIT;
    wire logic [ROW_W-1:0] row_pl = pass_d ? (row_n | plane_mask) : (row_n & ~plane_mask);
    wire logic [ROW_W-1:0] row_eff = (op_n == OP_TWO_PLANE) ? row_pl : row_n;
    // column bytes sent as zero on a random cache read
    wire logic [COL_W-1:0] col_eff = (op_n == OP_CACHE_RAND) ? '0 : col_n;
    wire logic [7:0] addr_byte =
        (aidx_d == '0) ? col_eff[7:0] :
        (aidx_d == ADDR_IDX_COL_HI) ? col_eff[15:8] :
        (aidx_d == ADDR_IDX_ROW_LO) ? row_eff[7:0] :
        (aidx_d == ADDR_IDX_ROW_MID) ? row_eff[15:8] : row_eff[23:16];
    wire logic [7:0] wr_byte = (st_d == ST_CMD1) ? first_cmd(op_n) :
                               (st_d == ST_CMD2) ? last_cmd(op_n) : addr_byte;
    wire logic sample = (st_q == ST_READ) && !ph_q && step_end;
    wire logic pop_take = pop_if.valid && (!out_valid || out_ready);

    assign push_if.valid = sample;
    assign push_if.data = io_in;
    assign pop_if.ready = pop_take;

    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q + 8'h01;
        ph_d = ph_q;
        aidx_d = aidx_q;
        pass_d = pass_q;
        rem_d = rem_q;
        finish = 1'b0;
        case (st_q)
            ST_IDLE: begin
                tmr_d = '0;
                ph_d = 1'b0;
                aidx_d = '0;
                pass_d = 1'b0;
                if (start) begin
                    st_d = ST_CMD1;
                    rem_d = cmd_len;
                end
            end
            ST_CMD1, ST_ADDR, ST_CMD2: begin
                if (step_end && !ph_q) begin
                    ph_d = 1'b1;
                    tmr_d = '0;
                end else if (step_end) begin
                    ph_d = 1'b0;
                    tmr_d = '0;
                    if (st_q == ST_CMD1 && n_addr != ADDR_NONE) begin
                        st_d = ST_ADDR;
                        aidx_d = '0;
                    end else if (st_q == ST_ADDR && aidx_q != n_addr - 3'h1) begin
                        aidx_d = aidx_q + 3'h1;
                    end else if (st_q == ST_ADDR && is_two && !pass_q) begin
                        // second 00h and plane-1 address before 30h
                        st_d = ST_CMD1;
                        pass_d = 1'b1;
                    end else if (st_q != ST_CMD2 && has_last) begin
                        // closing command after the last address byte
                        st_d = ST_CMD2;
                    end else begin
                        // writes ending in E0h go to the read wait
                        st_d = waits_busy ? ST_BUSY : ST_WHR;
                    end
                end
            end
            ST_BUSY: begin
                // hold off until ready_busy_n returns high
                if (tmr_q >= WR_TO_BUSY_CYC && ready_busy_n) begin
                    tmr_d = '0;
                    ph_d = 1'b1;
                    st_d = reads ? ST_READ : ST_IDLE;
                    finish = !reads;
                end else if (tmr_q >= WR_TO_BUSY_CYC) begin
                    tmr_d = tmr_q;
                end
            end
            ST_WHR: begin
                if (tmr_q == WR_TO_READ_CYC - 8'h01) begin
                    tmr_d = '0;
                    ph_d = 1'b1;
                    st_d = reads ? ST_READ : ST_IDLE;
                    finish = !reads;
                end
            end
            ST_READ: begin
                // bytes stream from the current column, one per strobe
                if (!ph_q && step_end) begin
                    ph_d = 1'b1;
                    tmr_d = '0;
                    rem_d = rem_q - LEN_W'(1);
                end else if (ph_q && step_end && rem_q == '0) begin
                    st_d = ST_IDLE;
                    finish = 1'b1;
                end else if (ph_q && step_end && push_if.ready) begin
                    ph_d = 1'b0;
                    tmr_d = '0;
                end else if (ph_q && step_end) begin
                    tmr_d = tmr_q;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    wire logic write_d = (st_d == ST_CMD1) || (st_d == ST_ADDR) || (st_d == ST_CMD2);

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= ST_IDLE;
            tmr_q <= '0;
            ph_q <= 1'b0;
            aidx_q <= '0;
            pass_q <= 1'b0;
            rem_q <= '0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            ph_q <= ph_d;
            aidx_q <= aidx_d;
            pass_q <= pass_d;
            rem_q <= rem_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            op_q <= OP_PAGE;
            col_q <= '0;
            row_q <= '0;
        end else if (start) begin
            op_q <= cmd_op;
            col_q <= cmd_col;
            row_q <= cmd_row;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            plane_pend_q <= 1'b0;
        end else if (finish && is_two) begin
            plane_pend_q <= 1'b1;
        end else if (start && cmd_op != OP_COL_OUT) begin
            plane_pend_q <= 1'b0;
        end
    end

    // pins: registered from the next state so every output is a flip-flop
    always_ff @(posedge clk) begin
        if (reset) begin
            chip_en_n <= 1'b1;
            command_latch_en <= 1'b0;
            address_latch_en <= 1'b0;
            write_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            io_out <= '0;
            io_oe <= 1'b0;
        end else begin
            chip_en_n <= (st_d == ST_IDLE);
            // latch enables mark command and address bytes
            command_latch_en <= (st_d == ST_CMD1) || (st_d == ST_CMD2);
            address_latch_en <= (st_d == ST_ADDR);
            write_strobe_n <= !(write_d && !ph_d);
            read_strobe_n <= !((st_d == ST_READ) && !ph_d);
            io_oe <= write_d;
            io_out <= write_d ? wr_byte : '0;
        end
    end

    // request-side flags
    always_ff @(posedge clk) begin
        if (reset) begin
            cmd_ready <= 1'b0;
            cmd_done <= 1'b0;
            cmd_error <= 1'b0;
        end else begin
            // new commands only while the device shows ready
            cmd_ready <= (st_d == ST_IDLE) && !accept && ready_busy_n;
            cmd_done <= finish;
            cmd_error <= accept && refuse;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (pop_take) begin
            out_valid <= 1'b1;
            out_data <= pop_if.data;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule : nrd_host
`default_nettype wire

/* File: rtl/nrd_pkg.sv */
// constants, commands and types for the nand read-side host sequencer
package nrd_pkg;
    // command bytes driven with command_latch_en high
    localparam logic [7:0] CMD_READ_SETUP = 8'h00;
    localparam logic [7:0] CMD_READ_GO = 8'h30;
    localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
    localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
    localparam logic [7:0] CMD_COL_OUT = 8'h05;
    localparam logic [7:0] CMD_PLANE_OUT = 8'h06;
    localparam logic [7:0] CMD_OUT_GO = 8'hE0;

    // address cycle counts and byte indices
    localparam logic [2:0] ADDR_NONE = 3'h0;
    localparam logic [2:0] ADDR_COL = 3'h2;
    localparam logic [2:0] ADDR_FULL = 3'h5;
    localparam logic [2:0] ADDR_IDX_COL_HI = 3'h1;
    localparam logic [2:0] ADDR_IDX_ROW_LO = 3'h2;
    localparam logic [2:0] ADDR_IDX_ROW_MID = 3'h3;

    // pin timing in ns, clock period in ns
    localparam int CLK_PERIOD_NS = 32'h0000_0019;
    localparam int T_WE_LOW_NS = 32'h0000_0019;
    localparam int T_WE_HIGH_NS = 32'h0000_0019;
    localparam int T_RE_LOW_NS = 32'h0000_0019;
    localparam int T_RE_HIGH_NS = 32'h0000_0019;
    localparam int T_WR_TO_BUSY_NS = 32'h0000_0064;
    localparam int T_WR_TO_READ_NS = 32'h0000_003C;

    // least time to whole cycles, never below one
    function automatic logic [7:0] nrd_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return 8'(c);
    endfunction : nrd_cycles

    localparam logic [7:0] WE_LOW_CYC = nrd_cycles(T_WE_LOW_NS);
    localparam logic [7:0] WE_HIGH_CYC = nrd_cycles(T_WE_HIGH_NS);
    localparam logic [7:0] RE_LOW_CYC = nrd_cycles(T_RE_LOW_NS);
    localparam logic [7:0] RE_HIGH_CYC = nrd_cycles(T_RE_HIGH_NS);
    localparam logic [7:0] WR_TO_BUSY_CYC = nrd_cycles(T_WR_TO_BUSY_NS);
    localparam logic [7:0] WR_TO_READ_CYC = nrd_cycles(T_WR_TO_READ_NS);

    typedef enum logic [2:0] {
        OP_PAGE = 3'h0,
        OP_CACHE_SEQ = 3'h1,
        OP_CACHE_RAND = 3'h2,
        OP_CACHE_LAST = 3'h3,
        OP_TWO_PLANE = 3'h4,
        OP_COL_OUT = 3'h5,
        OP_PLANE_OUT = 3'h6
    } nrd_op_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_CMD1 = 7'h02,
        ST_ADDR = 7'h04,
        ST_CMD2 = 7'h08,
        ST_BUSY = 7'h10,
        ST_WHR = 7'h20,
        ST_READ = 7'h40
    } nrd_state_t;
endpackage : nrd_pkg

/* File: rtl/nrd_byte_if.sv */
// valid/ready byte stream between the sequencer and its fifo
`timescale 1ns/1ps
`default_nettype none
interface nrd_byte_if #(
    parameter int WIDTH = 8
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : nrd_byte_if
`default_nettype wire

/* File: rtl/nrd_fifo.sv */
// parameterised fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module nrd_fifo
    import nrd_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic reset,
    nrd_byte_if.snk push,
    nrd_byte_if.src pop
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_q;
    logic [AW:0] rd_ptr_q;
    wire logic empty;
    wire logic full;
    wire logic do_push;
    wire logic do_pop;

    assign empty = (wr_ptr_q == rd_ptr_q);
    assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    assign push.ready = !full;
    assign pop.valid = !empty;
    assign pop.data = mem[rd_ptr_q[AW-1:0]];
    assign do_push = push.valid && !full;
    assign do_pop = pop.ready && !empty;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_q[AW-1:0]] <= push.data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_q + (AW+1)'(do_push);
            rd_ptr_q <= rd_ptr_q + (AW+1)'(do_pop);
        end
    end
endmodule : nrd_fifo
`default_nettype wire

/* File: bench/nrd_host_monitor.sv */
// pin-level assertions on the nand read host sequencer
`timescale 1ns/1ps
`default_nettype none
module nrd_host_monitor
    import nrd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic chip_en_n,
    input wire logic command_latch_en,
    input wire logic address_latch_en,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [7:0] io_out,
    input wire logic io_oe,
    input wire logic ready_busy_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_we_pulse;
        $fell(write_strobe_n) |=> write_strobe_n;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write strobe low too long");
    property p_latch_excl;
        !(command_latch_en && address_latch_en);
    endproperty
    a_latch_excl: assert property (p_latch_excl) else $error("both latches high");
    property p_re_quiet;
        !read_strobe_n |-> !command_latch_en && !address_latch_en && !io_oe && write_strobe_n;
    endproperty
    a_re_quiet: assert property (p_re_quiet) else $error("read strobe with latch or drive");
    property p_we_drive;
        !write_strobe_n |-> io_oe && !chip_en_n;
    endproperty
    a_we_drive: assert property (p_we_drive) else $error("write strobe without drive");
    property p_no_status;
        !write_strobe_n && command_latch_en |-> io_out != 8'h78;
    endproperty
    a_no_status: assert property (p_no_status) else $error("enhanced status issued");
    property p_e0_wait;
        $rose(write_strobe_n) && command_latch_en && io_out == CMD_OUT_GO |=> read_strobe_n[*3];
    endproperty
    a_e0_wait: assert property (p_e0_wait) else $error("read too soon after E0");
    property p_go_busy;
        $rose(write_strobe_n) && command_latch_en && (io_out == CMD_READ_GO
            || io_out == CMD_CACHE_NEXT || io_out == CMD_CACHE_LAST) |=> read_strobe_n[*4];
    endproperty
    a_go_busy: assert property (p_go_busy) else $error("read before busy poll");
    property p_read_ready;
        $fell(read_strobe_n) |-> ready_busy_n;
    endproperty
    a_read_ready: assert property (p_read_ready) else $error("read while busy");
endmodule : nrd_host_monitor

bind nrd_host nrd_host_monitor u_mon (.clk(clk), .reset(reset), .chip_en_n(chip_en_n),
    .command_latch_en(command_latch_en), .address_latch_en(address_latch_en),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
    .io_oe(io_oe), .ready_busy_n(ready_busy_n));
`default_nettype wire

/* File: bench/nrd_flash_model.sv */
// behavioural nand device answering the host sequencer pins
`timescale 1ns/1ps
`default_nettype none
module nrd_flash_model
    import nrd_pkg::*;
#(
    parameter int PLANE_BIT = 6,
    parameter int T_R_NS = 1000,
    parameter int T_CB_NS = 400,
    parameter int T_WHR_NS = 60
) (
    input wire logic chip_en_n,
    input wire logic command_latch_en,
    input wire logic address_latch_en,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [7:0] io_bus,
    input wire logic slow,
    output logic [7:0] dq = 8'h00,
    output logic ready_busy_n = 1'b1,
    output int fault_cnt = 0
);
    logic [23:0] cr [2];
    logic [23:0] dr, ra, r0;
    logic [15:0] col = 16'h0000;
    logic [15:0] ca;
    logic [7:0] last;
    logic [1:0] st65, fin;
    logic psel = 1'b0;
    logic need_sel = 1'b0;
    int na = 0;
    int n00 = 0;
    int busy_ns;
    realtime t_e0 = -1000.0;
    event go_busy;

    task automatic begin_busy(input int ns, input logic [1:0] f);
        busy_ns = ns;
        fin = f;
        -> go_busy;
    endtask : begin_busy

    always @(go_busy) begin
        ready_busy_n = 1'b0;
        st65 = 2'b00;
        #(busy_ns * (slow ? 3 : 1));
        ready_busy_n = 1'b1;
        st65 = fin;
    end

    always @(posedge write_strobe_n) begin
        if (!chip_en_n && address_latch_en) begin
            if (na < 2) ca[8*na +: 8] = io_bus;
            else ra[8*(na-2) +: 8] = io_bus;
            na++;
        end
        if (!chip_en_n && command_latch_en) begin
            case (io_bus)
                CMD_READ_SETUP: begin
                    if (n00 == 1) r0 = ra;
                    n00++;
                    na = 0;
                end
                CMD_READ_GO: begin
                    if (n00 == 2) begin
                        if (r0 != (ra & ~(24'h00_0001 << PLANE_BIT)) || !ra[PLANE_BIT]) fault_cnt++;
                        cr[0] = r0;
                        cr[1] = ra;
                        need_sel = 1'b1;
                    end else begin
                        cr[0] = ra;
                        dr = ra;
                        psel = 1'b0;
                        col = ca;
                    end
                    begin_busy(T_R_NS, 2'b11);
                end
                CMD_CACHE_NEXT: begin
                    // random form carries five address bytes
                    if (n00 == 1 && na != 5) fault_cnt++;
                    // hand out old page, fetch next or row only
                    cr[0] = dr;
                    dr = (n00 == 1) ? ra : dr + 24'h00_0001;
                    psel = 1'b0;
                    col = 16'h0000;
                    begin_busy(T_CB_NS, 2'b10);
                end
                CMD_CACHE_LAST: begin
                    cr[0] = dr;
                    psel = 1'b0;
                    col = 16'h0000;
                    begin_busy(T_CB_NS, 2'b11);
                end
                CMD_COL_OUT, CMD_PLANE_OUT: na = 0;
                CMD_OUT_GO: begin
                    if (!ready_busy_n) fault_cnt++;
                    if (last == CMD_PLANE_OUT) begin
                        psel = ra[PLANE_BIT];
                        need_sel = 1'b0;
                    end
                    col = ca;
                    t_e0 = $realtime;
                end
                default: fault_cnt++;
            endcase
            if (io_bus != CMD_READ_SETUP) n00 = 0;
            last = io_bus;
        end
    end

    // stream from the selected cache register
    always @(negedge read_strobe_n) begin
        // cache data only read once status shows it available
        if (need_sel || st65 == 2'b00 || $realtime - t_e0 < T_WHR_NS) fault_cnt++;
        dq = cr[psel][7:0] ^ col[7:0];
    end
    // released bus shows the inverse of the last byte
    always @(posedge read_strobe_n) begin
        if (!chip_en_n) begin
            col++;
            dq = ~dq;
        end
    end
endmodule : nrd_flash_model
`default_nettype wire

/* File: bench/nrd_host_tb.sv */
// self-checking bench for the nand read host sequencer
`timescale 1ns/1ps
`default_nettype none
module nrd_host_tb
    import nrd_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    nrd_op_t cmd_op = OP_PAGE;
    logic [15:0] cmd_col = 16'h0000;
    logic [23:0] cmd_row = 24'h00_0000;
    logic [11:0] cmd_len = 12'h000;
    logic out_ready = 1'b0;
    logic slow = 1'b0;
    logic cmd_ready, cmd_done, cmd_error, out_valid, chip_en_n, command_latch_en;
    logic address_latch_en, write_strobe_n, read_strobe_n, io_oe, ready_busy_n;
    logic [7:0] out_data, io_out, dq;
    int fault_cnt;
    int err_count = 0;
    int n_checks = 0;
    wire logic [7:0] io_bus = (io_oe === 1'b1) ? io_out : dq;

    always #12.5 clk = ~clk;

    nrd_host dut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_col(cmd_col), .cmd_row(cmd_row), .cmd_len(cmd_len), .cmd_ready(cmd_ready),
        .cmd_done(cmd_done), .cmd_error(cmd_error), .out_valid(out_valid),
        .out_data(out_data), .out_ready(out_ready), .chip_en_n(chip_en_n),
        .command_latch_en(command_latch_en), .address_latch_en(address_latch_en),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
        .io_oe(io_oe), .io_in(io_bus), .ready_busy_n(ready_busy_n));
    nrd_flash_model u_flash (.chip_en_n(chip_en_n), .command_latch_en(command_latch_en),
        .address_latch_en(address_latch_en), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .io_bus(io_bus), .slow(slow), .dq(dq),
        .ready_busy_n(ready_busy_n), .fault_cnt(fault_cnt));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // one request, stream collected with an optional stall, bytes compared
    task automatic run(input nrd_op_t op, input logic [15:0] c, input logic [23:0] r,
            input logic [11:0] n, input logic [7:0] pg, input logic [7:0] c0,
            input logic er, input int stall);
        int t;
        logic fin;
        logic e;
        logic [7:0] got [$];
        fin = 1'b0;
        e = 1'b0;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_col = c;
        cmd_row = r;
        cmd_len = n;
        for (t = 0; t < 2000 && cmd_ready !== 1'b1; t++) @(posedge clk) #1;
        @(posedge clk) #1;
        cmd_valid = 1'b0;
        for (t = 0; t < 4000 && !(fin && got.size() >= int'(n)); t++) begin
            out_ready = (t >= stall);
            if (out_valid === 1'b1 && out_ready) got.push_back(out_data);
            if (cmd_done === 1'b1 || cmd_error === 1'b1) begin
                fin = 1'b1;
                e = cmd_error;
            end
            @(posedge clk) #1;
        end
        chk(32'(e), 32'(er));
        chk(32'(got.size()), 32'(n));
        for (t = 0; t < got.size(); t++) chk(32'(got[t]), 32'(pg ^ (c0 + 8'(t))));
    endtask : run

    task automatic t_page();
        run(OP_PAGE, 16'h0010, 24'h00_0140, 12'h008, 8'h40, 8'h10, 1'b0, 40);
    endtask : t_page

    task automatic t_cache();
        run(OP_PAGE, 16'h0000, 24'h00_0111, 12'h001, 8'h11, 8'h00, 1'b0, 0);
        run(OP_CACHE_SEQ, 16'h0000, 24'h00_0000, 12'h003, 8'h11, 8'h00, 1'b0, 0);
        run(OP_CACHE_SEQ, 16'h0000, 24'h00_0000, 12'h002, 8'h12, 8'h00, 1'b0, 3);
        run(OP_CACHE_RAND, 16'h0033, 24'h00_0155, 12'h002, 8'h13, 8'h00, 1'b0, 0);
        run(OP_CACHE_LAST, 16'h0000, 24'h00_0000, 12'h002, 8'h55, 8'h00, 1'b0, 0);
        run(OP_COL_OUT, 16'h0007, 24'h00_0000, 12'h002, 8'h55, 8'h07, 1'b0, 0);
    endtask : t_cache

    task automatic t_planes();
        run(OP_TWO_PLANE, 16'h0000, 24'h00_0280, 12'h000, 8'h00, 8'h00, 1'b0, 0);
        run(OP_COL_OUT, 16'h0004, 24'h00_0000, 12'h000, 8'h00, 8'h00, 1'b1, 0);
        run(OP_PLANE_OUT, 16'h0003, 24'h00_02C0, 12'h002, 8'hC0, 8'h03, 1'b0, 0);
        run(OP_PLANE_OUT, 16'h0000, 24'h00_0280, 12'h002, 8'h80, 8'h00, 1'b0, 0);
        run(OP_COL_OUT, 16'h0005, 24'h00_0000, 12'h003, 8'h80, 8'h05, 1'b0, 0);
    endtask : t_planes

    initial begin
        #400_000;
        err_count++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge clk);
        #1;
        reset = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        t_page();
        t_cache();
        slow = 1'b1;
        t_planes();
        chk(32'(fault_cnt), 32'h0000_0000);
        conclude();
    end
endmodule : nrd_host_tb
`default_nettype wire
